// ==== pcgc_baud.sv ====
// Purpose: optional halving of the Timer 1 overflow before the UART
// Assumes: t1_overflow is a one-cycle pulse on the same clock
// Notes: the halver phase is kept while doubling is on
`timescale 1ns/1ns
module pcgc_baud (
    input wire logic clock,
    input wire logic rst,
    pcgc_ctrl_if.baud ctrl
);
    typedef struct packed {
        logic phase;
        logic tick;
    } pcgc_baud_state_type;

    pcgc_baud_state_type state;
    pcgc_baud_state_type next_state;

    // pass every overflow, or every second one
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (ctrl.t1_overflow) begin
            if (ctrl.baud_double) begin
                next_state.tick = 1'b1; // [RULE6]
            end else begin
                next_state.phase = !state.phase;
                next_state.tick = state.phase; // [RULE6]
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state.phase <= 1'b0;
            state.tick <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign ctrl.uart_baud_tick = state.tick;
endmodule

// ==== pcgc_ctrl_if.sv ====
// Purpose: signals between the register core and its gating helpers
// Assumes: one clock domain
// Notes: clock_run bits are enables, not clocks
`timescale 1ns/1ns
interface pcgc_ctrl_if;
    logic [pcgc_pkg::periph_count-1:0] clock_off;
    logic power_down_any;
    logic [pcgc_pkg::periph_count-1:0] clock_run;
    logic baud_double;
    logic t1_overflow;
    logic uart_baud_tick;

    modport core (
        output clock_off,
        output power_down_any,
        input clock_run,
        output baud_double,
        output t1_overflow,
        input uart_baud_tick
    );
    modport gate (
        input clock_off,
        input power_down_any,
        output clock_run
    );
    modport baud (
        input baud_double,
        input t1_overflow,
        output uart_baud_tick
    );
endinterface

// ==== pcgc_gate.sv ====
// Purpose: registered run enables for each gated peripheral clock
// Assumes: clock_off and power_down_any come from the same clock
// Notes: one cycle from a register change to the enable
`timescale 1ns/1ns
module pcgc_gate (
    input wire logic clock,
    input wire logic rst,
    pcgc_ctrl_if.gate ctrl
);
    typedef struct packed {
        logic [pcgc_pkg::periph_count-1:0] run;
    } pcgc_gate_state_type;

    pcgc_gate_state_type state;
    pcgc_gate_state_type next_state;

    // ------------------------------------------------------------
    // per-peripheral enable
    // ------------------------------------------------------------
    logic [pcgc_pkg::periph_count-1:0] run_want;

    // each clock runs unless its own bit or a forced power-down stops it
    for (genvar i = 0; i < pcgc_pkg::periph_count; i++) begin : g_run
        assign run_want[i] = !ctrl.clock_off[i] &&
            !(ctrl.power_down_any && pcgc_pkg::forced_off_mask[i]); // [RULE8]
    end

    // next state
    always_comb begin
        next_state = state;
        next_state.run = run_want; // [RULE7] [RULE9] [RULE10] [RULE11] [RULE14]
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state.run <= pcgc_pkg::clock_run_reset;
        end else begin
            state <= next_state;
        end
    end

    assign ctrl.clock_run = state.run;
endmodule

// ==== pcgc_pkg.sv ====
// Purpose: constants and types for the power and clock gating control block
// Assumes: 8-bit registers at byte offsets on a plain strobe port
// Notes: peripheral order is uart, spi, iic, converter, rtc
// Summary of operation
// [RULE1] The low two bits of the power mode register pick the power mode and reset to zero.
// [RULE2] Mode code three is total power-down, which also silences brownout and comparators.
// [RULE3] Two spare flags at bits 2 and 3 are read and written freely and steer nothing.
// [RULE4] The brownout interrupt is raised only while bit 4 of the power mode register is one.
// [RULE5] Bit 6 routes serial control bit 7 to the serial mode bit or to the framing error flag.
// [RULE6] Bit 7 passes each Timer 1 overflow to the UART, else only every second one.
// [RULE7] Bit 1 of the gating register stops the UART clock.
// [RULE8] Either power-down mode stops the UART clock whatever bit 1 says.
// [RULE9] Bit 2 stops the SPI clock, and either power-down mode stops it too.
// [RULE10] Bit 3 stops the I2C clock, and either power-down mode stops it too.
// [RULE11] Bit 4 stops the converter clock; software should also clear the converter enables.
// [RULE12] Bit 5 powers the voltage comparators down.
// [RULE13] Software disables the comparators before it sets the comparator power-off bit.
// [RULE14] Bit 7 of the gating register stops the real-time clock.
// [RULE15] Reserved bits of both registers ignore writes and read as zero.
package pcgc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] power_mode_control_offset = 8'h87;
    localparam logic [7:0] peripheral_power_gating_offset = 8'hB5;
    localparam logic [7:0] power_mode_control_reset = 8'h00;
    localparam logic [7:0] peripheral_power_gating_reset = 8'h00;
    localparam logic [7:0] power_mode_control_wmask = 8'hDF;
    localparam logic [7:0] peripheral_power_gating_wmask = 8'hBE;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int power_mode_bit_low = 0;
    localparam int power_mode_bit_high = 1;
    localparam int spare_flag_a = 2;
    localparam int spare_flag_b = 3;
    localparam int brownout_irq_enable = 4;
    localparam int framing_error_select = 6;
    localparam int baud_double = 7;
    localparam int uart_clock_off = 1;
    localparam int spi_clock_off = 2;
    localparam int iic_clock_off = 3;
    localparam int converter_clock_off = 4;
    localparam int comparator_power_off = 5;
    localparam int rtc_clock_off = 7;

    // ------------------------------------------------------------
    // mode codes and peripheral indices
    // ------------------------------------------------------------
    localparam logic [1:0] mode_normal = 2'h0;
    localparam logic [1:0] mode_power_down = 2'h2;
    localparam logic [1:0] mode_total_power_down = 2'h3;
    localparam int periph_count = 5;
    localparam int periph_uart = 0;
    localparam int periph_spi = 1;
    localparam int periph_iic = 2;
    localparam int periph_converter = 3;
    localparam int periph_rtc = 4;
    // peripherals stopped by either power-down mode
    localparam logic [periph_count-1:0] forced_off_mask = 5'h07;
    localparam logic [periph_count-1:0] clock_run_reset = 5'h1F;

    typedef enum logic [1:0] {
        pcgc_mode_normal_type_v = 2'h0,
        pcgc_mode_other_type_v = 2'h1,
        pcgc_mode_pd_type_v = 2'h2,
        pcgc_mode_tpd_type_v = 2'h3
    } pcgc_mode_type;
endpackage

// ==== pcgc_top.sv ====
// Purpose: power mode and peripheral clock gating registers
// Assumes: brownout_detect is asynchronous, other inputs share clock
// Notes: peripheral clocks leave as run enables, one per block
`timescale 1ns/1ns
module pcgc_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic [1:0] power_mode,
    output logic power_down_active,
    output logic total_power_down,
    input wire logic brownout_detect,
    output logic brownout_irq,
    output logic brownout_reset_req,
    input wire logic comparator_irq_in,
    output logic comparator_irq,
    output logic comparator_power_on,
    input wire logic serial_mode_bit,
    input wire logic framing_error_flag,
    input wire logic serial_bit7_write,
    input wire logic serial_bit7_wdata,
    output logic serial_bit7_rdata,
    output logic serial_mode_write,
    output logic framing_error_write,
    output logic serial_bit7_wvalue,
    input wire logic t1_overflow,
    output logic uart_baud_tick,
    output logic uart_clock_run,
    output logic spi_clock_run,
    output logic iic_clock_run,
    output logic converter_clock_run,
    output logic rtc_clock_run
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 8) begin : g_addr_check
        $error("pcgc_top needs at least 8 address bits");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] power_mode_control;
        logic [7:0] peripheral_power_gating;
        logic [7:0] rdata;
        logic bo_meta;
        logic bo_sync;
        logic bo_irq;
        logic bo_reset;
        logic cmp_irq;
        logic sm_write;
        logic fe_write;
        logic bit7_wvalue;
        logic bit7_rdata;
    } pcgc_top_state_type;

    pcgc_top_state_type state;
    pcgc_top_state_type next_state;

    pcgc_ctrl_if ctrl ();

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic hit_pmc;
    logic hit_ppg;
    logic [1:0] mode;
    logic in_total_pd;
    logic in_any_pd;

    // address match on the printed offsets, upper bits must be zero
    assign hit_pmc = reg_addr ==
        ADDR_W'(pcgc_pkg::power_mode_control_offset);
    assign hit_ppg = reg_addr ==
        ADDR_W'(pcgc_pkg::peripheral_power_gating_offset);

    // mode field and its decodes
    assign mode = {
        state.power_mode_control[pcgc_pkg::power_mode_bit_high],
        state.power_mode_control[pcgc_pkg::power_mode_bit_low]
    }; // [RULE1]
    assign in_total_pd = mode == pcgc_pkg::mode_total_power_down; // [RULE2]
    assign in_any_pd = in_total_pd ||
        (mode == pcgc_pkg::mode_power_down); // [RULE8]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // register writes, reserved bits held at zero
        if (reg_write && hit_pmc) begin
            next_state.power_mode_control =
                reg_wdata & pcgc_pkg::power_mode_control_wmask; // [RULE15]
        end
        if (reg_write && hit_ppg) begin
            next_state.peripheral_power_gating =
                reg_wdata & pcgc_pkg::peripheral_power_gating_wmask; // [RULE15]
        end

        // read data for the following cycle only, zero if unmapped
        next_state.rdata = 8'h00;
        if (reg_read && hit_pmc) begin
            next_state.rdata = state.power_mode_control; // [RULE3]
        end else if (reg_read && hit_ppg) begin
            next_state.rdata = state.peripheral_power_gating;
        end

        // brownout synchroniser, second stage alone is read
        next_state.bo_meta = brownout_detect;
        next_state.bo_sync = state.bo_meta;

        // brownout paths are dead in total power-down
        next_state.bo_irq = state.bo_sync && !in_total_pd &&
            state.power_mode_control[pcgc_pkg::brownout_irq_enable]; // [RULE4]
        next_state.bo_reset = state.bo_sync && !in_total_pd; // [RULE2]

        // comparator interrupts masked when powered off
        next_state.cmp_irq = comparator_irq_in && !in_total_pd &&
            !state.peripheral_power_gating[pcgc_pkg::comparator_power_off];

        // serial control bit 7 routing
        next_state.sm_write = serial_bit7_write &&
            !state.power_mode_control[pcgc_pkg::framing_error_select]; // [RULE5]
        next_state.fe_write = serial_bit7_write &&
            state.power_mode_control[pcgc_pkg::framing_error_select]; // [RULE5]
        next_state.bit7_wvalue = serial_bit7_wdata;
        next_state.bit7_rdata =
            state.power_mode_control[pcgc_pkg::framing_error_select] ?
            framing_error_flag : serial_mode_bit; // [RULE5]
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state.power_mode_control <= pcgc_pkg::power_mode_control_reset;
            state.peripheral_power_gating <=
                pcgc_pkg::peripheral_power_gating_reset;
            state.rdata <= 8'h00;
            state.bo_meta <= 1'b0;
            state.bo_sync <= 1'b0;
            state.bo_irq <= 1'b0;
            state.bo_reset <= 1'b0;
            state.cmp_irq <= 1'b0;
            state.sm_write <= 1'b0;
            state.fe_write <= 1'b0;
            state.bit7_wvalue <= 1'b0;
            state.bit7_rdata <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // gate bits gathered in peripheral order
    assign ctrl.clock_off[pcgc_pkg::periph_uart] =
        state.peripheral_power_gating[pcgc_pkg::uart_clock_off]; // [RULE7]
    assign ctrl.clock_off[pcgc_pkg::periph_spi] =
        state.peripheral_power_gating[pcgc_pkg::spi_clock_off]; // [RULE9]
    assign ctrl.clock_off[pcgc_pkg::periph_iic] =
        state.peripheral_power_gating[pcgc_pkg::iic_clock_off]; // [RULE10]
    assign ctrl.clock_off[pcgc_pkg::periph_converter] =
        state.peripheral_power_gating[pcgc_pkg::converter_clock_off]; // [RULE11]
    assign ctrl.clock_off[pcgc_pkg::periph_rtc] =
        state.peripheral_power_gating[pcgc_pkg::rtc_clock_off]; // [RULE14]
    assign ctrl.power_down_any = in_any_pd;
    assign ctrl.baud_double =
        state.power_mode_control[pcgc_pkg::baud_double];
    assign ctrl.t1_overflow = t1_overflow;

    pcgc_gate u_gate (
        .clock(clock),
        .rst(rst),
        .ctrl(ctrl.gate)
    );

    pcgc_baud u_baud (
        .clock(clock),
        .rst(rst),
        .ctrl(ctrl.baud)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign power_mode = mode;
    assign power_down_active = in_any_pd;
    assign total_power_down = in_total_pd;
    assign brownout_irq = state.bo_irq;
    assign brownout_reset_req = state.bo_reset;
    assign comparator_irq = state.cmp_irq;
    // software has quiesced the comparators before this bit goes high
    assign comparator_power_on = !in_total_pd &&
        !state.peripheral_power_gating[pcgc_pkg::comparator_power_off]; // [RULE12] [RULE13]
    assign serial_bit7_rdata = state.bit7_rdata;
    assign serial_mode_write = state.sm_write;
    assign framing_error_write = state.fe_write;
    assign serial_bit7_wvalue = state.bit7_wvalue;
    assign uart_baud_tick = ctrl.uart_baud_tick;
    assign uart_clock_run = ctrl.clock_run[pcgc_pkg::periph_uart];
    assign spi_clock_run = ctrl.clock_run[pcgc_pkg::periph_spi];
    assign iic_clock_run = ctrl.clock_run[pcgc_pkg::periph_iic];
    assign converter_clock_run = ctrl.clock_run[pcgc_pkg::periph_converter];
    assign rtc_clock_run = ctrl.clock_run[pcgc_pkg::periph_rtc];
endmodule

// ==== pcgc_top_assertions.sv ====
// Purpose: port-level checks on the power and clock gating block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into pcgc_top at the foot of this file
`timescale 1ns/1ns
module pcgc_top_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] power_mode,
    input wire logic power_down_active,
    input wire logic total_power_down,
    input wire logic brownout_irq,
    input wire logic brownout_reset_req,
    input wire logic comparator_irq_in,
    input wire logic comparator_irq,
    input wire logic comparator_power_on,
    input wire logic serial_bit7_write,
    input wire logic serial_mode_write,
    input wire logic framing_error_write,
    input wire logic t1_overflow,
    input wire logic uart_baud_tick,
    input wire logic uart_clock_run,
    input wire logic spi_clock_run,
    input wire logic iic_clock_run
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // read data only in the cycle after a read
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside a read answer");
    // reserved bits read as zero
    reserved_zero_a: assert property ($past(reg_read) |->
        !($past(reg_addr) == 8'h87 && reg_rdata[5]) &&
        !($past(reg_addr) == 8'hB5 && (reg_rdata[0] || reg_rdata[6])))
        else $error("reserved bit read as one");
    mode_decode_a: assert property (power_down_active == power_mode[1] &&
        total_power_down == (power_mode == 2'h3))
        else $error("mode flags disagree with mode field");
    uart_forced_a: assert property ($past(power_down_active) |-> !uart_clock_run)
        else $error("uart clock runs in power-down");
    spi_forced_a: assert property ($past(power_down_active) |-> !spi_clock_run)
        else $error("spi clock runs in power-down");
    iic_forced_a: assert property ($past(power_down_active) |-> !iic_clock_run)
        else $error("iic clock runs in power-down");
    bod_silent_a: assert property ($past(total_power_down) |->
        !brownout_irq && !brownout_reset_req)
        else $error("brownout active in total power-down");
    comp_gate_a: assert property ($past(total_power_down) ||
        !$past(comparator_irq_in) |-> !comparator_irq)
        else $error("comparator interrupt without cause");
    comp_power_a: assert property (total_power_down |-> !comparator_power_on)
        else $error("comparators powered in total power-down");
    baud_cause_a: assert property (uart_baud_tick |-> $past(t1_overflow))
        else $error("baud tick without overflow");
    route_one_a: assert property (serial_mode_write || framing_error_write |->
        $past(serial_bit7_write) && !(serial_mode_write && framing_error_write))
        else $error("bit 7 write misrouted");
endmodule
bind pcgc_top pcgc_top_assertions #(.ADDR_W(ADDR_W)) pcgc_top_assertions_inst (
    .clock, .rst, .reg_addr, .reg_read, .reg_rdata, .power_mode,
    .power_down_active, .total_power_down, .brownout_irq,
    .brownout_reset_req, .comparator_irq_in, .comparator_irq,
    .comparator_power_on, .serial_bit7_write, .serial_mode_write,
    .framing_error_write, .t1_overflow, .uart_baud_tick,
    .uart_clock_run, .spi_clock_run, .iic_clock_run
);

// ==== tb_top.sv ====
// Purpose: self-checking bench for the power and clock gating block
// Assumes: strobe register port, read data the cycle after a read
// Notes: run enables are packed rtc..uart for comparison
`timescale 1ns/1ns
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic brownout_detect = 1'b0;
    logic comparator_irq_in = 1'b0;
    logic serial_mode_bit = 1'b0;
    logic framing_error_flag = 1'b0;
    logic serial_bit7_write = 1'b0;
    logic serial_bit7_wdata = 1'b0;
    logic t1_overflow = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] power_mode;
    logic pda, tpd, bo_irq, bo_rst, cmp_irq, cmp_on, b7_rd, sm_wr, fe_wr;
    logic b7_wv, tick, r_uart, r_spi, r_iic, r_conv, r_rtc;
    logic [4:0] runs;
    int bad_count = 0;
    int checks_done = 0;
    int ticks = 0;
    assign runs = {r_rtc, r_conv, r_iic, r_spi, r_uart};

    pcgc_top pcgc_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .power_mode(power_mode),
        .power_down_active(pda), .total_power_down(tpd),
        .brownout_detect(brownout_detect), .brownout_irq(bo_irq),
        .brownout_reset_req(bo_rst), .comparator_irq_in(comparator_irq_in),
        .comparator_irq(cmp_irq), .comparator_power_on(cmp_on),
        .serial_mode_bit(serial_mode_bit),
        .framing_error_flag(framing_error_flag),
        .serial_bit7_write(serial_bit7_write),
        .serial_bit7_wdata(serial_bit7_wdata), .serial_bit7_rdata(b7_rd),
        .serial_mode_write(sm_wr), .framing_error_write(fe_wr),
        .serial_bit7_wvalue(b7_wv), .t1_overflow(t1_overflow),
        .uart_baud_tick(tick), .uart_clock_run(r_uart),
        .spi_clock_run(r_spi), .iic_clock_run(r_iic),
        .converter_clock_run(r_conv), .rtc_clock_run(r_rtc));

    // 100 MHz clock
    always #5 clock = ~clock;
    // count baud ticks
    always @(posedge clock) if (tick === 1'b1) ticks++;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(8'h87, 8'h00);
        rd(8'hB5, 8'h00);
        chk({3'h0, runs}, 8'h1F);
        wr(8'h87, 8'hFF);
        rd(8'h87, 8'hDF);
        wr(8'hB5, 8'hFF);
        rd(8'hB5, 8'hBE);
        wr(8'h87, 8'h00);
        wr(8'hB5, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h87, 8'h00);
        rd(8'h55, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_gate;
        int gb[5] = '{1, 2, 3, 4, 7};
        for (int i = 0; i < 5; i++) begin
            wr(8'hB5, 8'h01 << gb[i]);
            settle(1);
            chk({3'h0, runs}, {3'h0, 5'h1F & ~(5'h01 << i)});
        end
        // comparators are idle here, so powering them off is allowed
        wr(8'hB5, 8'h20);
        settle(1);
        chk({7'h00, cmp_on}, 8'h00);
        chk({3'h0, runs}, 8'h1F);
        wr(8'hB5, 8'h00);
        $display("test gate done");
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(8'h87, 8'h0C | 8'(m));
            #1 chk({6'h00, power_mode}, 8'(m));
            chk({6'h00, pda, tpd}, {6'h00, m[1], m == 3});
            chk({7'h00, cmp_on}, {7'h00, m != 3});
            settle(1);
            chk({3'h0, runs}, m[1] ? 8'h18 : 8'h1F);
        end
        wr(8'h87, 8'h00);
        $display("test modes done");
    endtask
    task automatic t_baud;
        int start;
        for (int d = 0; d < 2; d++) begin
            wr(8'h87, d ? 8'h80 : 8'h00);
            start = ticks;
            repeat (4) begin
                @(posedge clock);
                t1_overflow <= 1'b1;
                @(posedge clock);
                t1_overflow <= 1'b0;
            end
            settle(2);
            chk(8'(ticks - start), d ? 8'h04 : 8'h02);
        end
        wr(8'h87, 8'h00);
        $display("test baud done");
    endtask
    task automatic t_serial;
        serial_mode_bit <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            wr(8'h87, s ? 8'h40 : 8'h00);
            settle(2);
            chk({7'h00, b7_rd}, {7'h00, s == 0});
            @(posedge clock);
            serial_bit7_write <= 1'b1;
            serial_bit7_wdata <= (s == 0);
            @(posedge clock);
            serial_bit7_write <= 1'b0;
            #1 chk({5'h00, sm_wr, fe_wr, b7_wv}, s ? 8'h02 : 8'h05);
        end
        // framing error flag must reach bit 7 while the select is one
        @(posedge clock);
        serial_mode_bit <= 1'b0;
        framing_error_flag <= 1'b1;
        settle(2);
        chk({7'h00, b7_rd}, 8'h01);
        $display("test serial done");
    endtask
    task automatic t_bod;
        wr(8'h87, 8'h10);
        brownout_detect <= 1'b1;
        settle(4);
        chk({6'h00, bo_irq, bo_rst}, 8'h03);
        wr(8'h87, 8'h00);
        settle(2);
        chk({6'h00, bo_irq, bo_rst}, 8'h01);
        wr(8'h87, 8'h13);
        comparator_irq_in <= 1'b1;
        settle(2);
        chk({5'h00, bo_irq, bo_rst, cmp_irq}, 8'h00);
        wr(8'h87, 8'h00);
        settle(2);
        chk({7'h00, cmp_irq}, 8'h01);
        wr(8'hB5, 8'h20);
        settle(2);
        chk({7'h00, cmp_irq}, 8'h00);
        wr(8'hB5, 8'h00);
        brownout_detect <= 1'b0;
        comparator_irq_in <= 1'b0;
        $display("test brownout done");
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_gate;
        t_modes;
        t_baud;
        t_serial;
        t_bod;
        close_out;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        close_out;
    end
endmodule
